// file: hdl/dpi_fifo.sv
// constants package, and a shift-register fifo with its head word and valid in flip-flops
//
// Function
// - termination follows registered termination-enable level
// - x16: terminate sixteen data, both strobes, masks
// - x8: terminate eight data (lower byte lane), one strobe, mask; complement strobe only if enabled
// - x4: terminate four data, one strobe, mask
// - mode-register disable makes termination-enable ignored
// - command decoded from chip select, row, column, write
// - reset active low, asynchronous both ways
// - upper mask high discards upper byte
// - lines 7..0 lower byte, 15..8 upper
// - lower strobe edge-aligned with read data
// - upper strobe edge-aligned with read data in x16 only
// - chip select high masks every command
// - lower mask high discards lower byte
// - control inputs sampled on rising clock
package dpi_pkg;
  // organisation strap codes
  localparam logic [1:0] ORG_X4 = 2'h0;
  localparam logic [1:0] ORG_X8 = 2'h1;
  localparam logic [1:0] ORG_X16 = 2'h2;
  // mode register that holds the termination controls, and its fields
  localparam logic [2:0] MR_TERM_BANK = 3'h1;
  localparam int MR_TERM_EN_BIT = 2;
  localparam int MR_TSTROBE_BIT = 11;
  localparam logic MR_TERM_EN_RESET = 1'b1;
  localparam logic MR_TSTROBE_RESET = 1'b0;
  // byte lanes of the data bus
  localparam int LOW_LSB = 0;
  localparam int UP_LSB = 8;
  localparam int BYTE_W = 8;
  localparam int DQ_W = 16;
  localparam int ADDR_W = 14;
  localparam int BANK_W = 3;
  // write beats are taken this many link clocks after the command
  localparam int WR_LAT = 1;
  localparam int FIFO_DEPTH = 4;
  localparam int WORD_W = BANK_W + ADDR_W + 2 + DQ_W;
  // decoded commands
  typedef enum logic [2:0] {
    CMD_DESELECT, CMD_MODE_LOAD, CMD_REFRESH, CMD_PRECHARGE,
    CMD_ACTIVATE, CMD_WRITE, CMD_READ, CMD_NOP
  } dpi_cmd_t;
  typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_DRIVE} dpi_rd_state_t;
endpackage

`timescale 1ns/1ns
`default_nettype none

module dpi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic [CW-1:0] wr_idx;
  logic vld;

  wire push = in_valid_i && in_ready_o;
  wire pop = vld && out_ready_i;

  assign in_ready_o = (count < CW'(DEPTH));
  assign out_valid_o = vld;
  assign out_data_o = mem[0];
  assign wr_idx = pop ? count - CW'(1) : count;
  assign next_count = count + CW'(push) - CW'(pop);

  // shift down on pop, then place the new word behind the last valid one
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      if (pop) begin
        next_mem[i] = (i == DEPTH - 1) ? '0 : mem[(i + 1) % DEPTH];
      end else begin
        next_mem[i] = mem[i];
      end
      if (push && (wr_idx == CW'(i))) begin
        next_mem[i] = in_data_i;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count <= '0;
      vld <= 1'b0;
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else begin
      count <= next_count;
      vld <= (next_count != '0);
      mem <= next_mem;
    end
  end

endmodule

`default_nettype wire

// file: hdl/dpi_top.sv
// pin-level ddr3 interface with its core-side write and read ports
`timescale 1ns/1ns
`default_nettype none

module dpi_top
  import dpi_pkg::*;
(
  // core clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // link clock (true clock; complement crossing is the same edge)
  input wire logic link_clk_i,
  // organisation strap
  input wire logic [1:0] org_i,
  // command and address pins
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [BANK_W-1:0] bank_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic termination_enable_i,
  // data pins
  input wire logic [DQ_W-1:0] dq_i,
  output logic [DQ_W-1:0] dq_o,
  output logic dq_oe_o,
  input wire logic lower_write_mask_i,
  input wire logic upper_write_mask_i,
  output logic lower_byte_strobe_o,
  output logic lower_byte_strobe_n_o,
  output logic upper_byte_strobe_o,
  output logic upper_byte_strobe_n_o,
  output logic strobe_oe_o,
  // termination status per ball group
  output logic [DQ_W-1:0] term_dq_o,
  output logic [1:0] term_strobe_o,
  output logic [1:0] term_mask_o,
  output logic term_strobe_n_ball_o,
  output logic termination_strobe_en_o,
  // core write port
  output logic wr_valid_o,
  input wire logic wr_ready_i,
  output logic [BANK_W-1:0] wr_bank_o,
  output logic [ADDR_W-1:0] wr_addr_o,
  output logic [1:0] wr_byte_en_o,
  output logic [DQ_W-1:0] wr_data_o,
  output logic wr_in_ready_o,
  output logic wr_overflow_o,
  // core read port
  output logic rd_req_o,
  output logic [BANK_W-1:0] rd_bank_o,
  output logic [ADDR_W-1:0] rd_addr_o,
  input wire logic rd_valid_i,
  input wire logic [DQ_W-1:0] rd_data_i
);

  //////////////////////////////////////////////////////////////////////////
  // command decode shared by the link logic

  function automatic dpi_cmd_t decode_cmd(input logic cs_n, input logic ras_n,
                                          input logic cas_n, input logic we_n);
    dpi_cmd_t c;
    c = CMD_NOP;
    if (cs_n) begin
      c = CMD_DESELECT;
    end else begin
      case ({ras_n, cas_n, we_n})
        3'h0: c = CMD_MODE_LOAD;
        3'h1: c = CMD_REFRESH;
        3'h2: c = CMD_PRECHARGE;
        3'h3: c = CMD_ACTIVATE;
        3'h4: c = CMD_WRITE;
        3'h5: c = CMD_READ;
        default: c = CMD_NOP;
      endcase
    end
    return c;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // link domain: pins sampled on the rising true clock

  logic [1:0] org_s1;
  logic [1:0] org;
  logic mr_term_en;
  logic mr_tstrobe;
  logic wr_pend;
  logic [BANK_W-1:0] wr_bank_l;
  logic [ADDR_W-1:0] wr_addr_l;
  logic [WORD_W-1:0] wr_word_l;
  logic wr_tog_l;
  logic [BANK_W-1:0] rd_bank_l;
  logic [ADDR_W-1:0] rd_addr_l;
  logic rd_tog_l;
  logic rd_tog_c;
  logic [DQ_W-1:0] rd_word_c;
  logic rdd_s1;
  logic rdd_s2;
  logic rdd_s3;
  dpi_rd_state_t rd_state;
  dpi_rd_state_t next_rd_state;

  // every control input of the link is taken on this edge
  wire dpi_cmd_t cmd = decode_cmd(cs_n_i, ras_n_i, cas_n_i, we_n_i);
  wire is_mode_load = (cmd == CMD_MODE_LOAD);
  wire is_term_mr = is_mode_load && (bank_i == MR_TERM_BANK);
  wire is_write = (cmd == CMD_WRITE);
  wire is_read = (cmd == CMD_READ);
  wire rd_data_evt = rdd_s2 ^ rdd_s3;

  // termination is on only while enabled in the mode register and the pin is high
  wire term_on = mr_term_en && termination_enable_i;
  wire org_x16 = (org == ORG_X16);
  wire org_x8 = (org == ORG_X8);
  wire org_x4 = (org == ORG_X4);
  wire [DQ_W-1:0] dq_lanes = org_x16 ? 16'hffff :
                             org_x8 ? 16'h00ff :
                             org_x4 ? 16'h000f : 16'h0000;
  wire [1:0] strobe_lanes = org_x16 ? 2'h3 : (org_x8 || org_x4) ? 2'h1 : 2'h0;
  wire tstrobe_ball = org_x8 && mr_tstrobe;

  // masked bytes are dropped: zero data and byte enable low
  wire keep_low = !lower_write_mask_i;
  wire keep_up = !upper_write_mask_i;
  wire [BYTE_W-1:0] beat_low = keep_low ? dq_i[LOW_LSB +: BYTE_W] : 8'h00;
  wire [BYTE_W-1:0] beat_up = keep_up ? dq_i[UP_LSB +: BYTE_W] : 8'h00;
  wire [WORD_W-1:0] beat_word = {wr_bank_l, wr_addr_l, keep_up, keep_low, beat_up, beat_low};

  // strap and read-data toggle cross in via two flip-flops
  always_ff @(posedge link_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      org_s1 <= ORG_X16;
      org <= ORG_X16;
      rdd_s1 <= 1'b0;
      rdd_s2 <= 1'b0;
      rdd_s3 <= 1'b0;
    end else begin
      org_s1 <= org_i;
      org <= org_s1;
      rdd_s1 <= rd_tog_c;
      rdd_s2 <= rdd_s1;
      rdd_s3 <= rdd_s2;
    end
  end

  // mode register fields and termination outputs
  always_ff @(posedge link_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mr_term_en <= MR_TERM_EN_RESET;
      mr_tstrobe <= MR_TSTROBE_RESET;
      term_dq_o <= '0;
      term_strobe_o <= '0;
      term_mask_o <= '0;
      term_strobe_n_ball_o <= 1'b0;
    end else begin
      if (is_term_mr) begin
        mr_term_en <= addr_i[MR_TERM_EN_BIT];
        mr_tstrobe <= addr_i[MR_TSTROBE_BIT];
      end
      term_dq_o <= term_on ? dq_lanes : '0;
      term_strobe_o <= term_on ? strobe_lanes : 2'h0;
      term_mask_o <= term_on ? strobe_lanes : 2'h0;
      term_strobe_n_ball_o <= term_on && tstrobe_ball;
    end
  end

  // write beat one link clock after the command, handed across by toggle
  always_ff @(posedge link_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_pend <= 1'b0;
      wr_bank_l <= '0;
      wr_addr_l <= '0;
      wr_word_l <= '0;
      wr_tog_l <= 1'b0;
    end else begin
      wr_pend <= is_write;
      if (is_write) begin
        wr_bank_l <= bank_i;
        wr_addr_l <= addr_i;
      end
      if (wr_pend) begin
        wr_word_l <= beat_word;
        wr_tog_l <= !wr_tog_l;
      end
    end
  end

  // read sequencing: request to core, wait for the word, drive one beat
  always_comb begin
    next_rd_state = rd_state;
    case (rd_state)
      RD_IDLE: if (is_read) next_rd_state = RD_WAIT;
      RD_WAIT: if (rd_data_evt) next_rd_state = RD_DRIVE;
      RD_DRIVE: next_rd_state = RD_IDLE;
      default: next_rd_state = RD_IDLE;
    endcase
  end

  wire rd_take = (rd_state == RD_IDLE) && is_read;
  wire rd_launch = (rd_state == RD_WAIT) && rd_data_evt;

  always_ff @(posedge link_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_state <= RD_IDLE;
      rd_bank_l <= '0;
      rd_addr_l <= '0;
      rd_tog_l <= 1'b0;
    end else begin
      rd_state <= next_rd_state;
      if (rd_take) begin
        rd_bank_l <= bank_i;
        rd_addr_l <= addr_i;
        rd_tog_l <= !rd_tog_l;
      end
    end
  end

  // read data and lower strobe launched together on the same edge; upper strobe too in x16 only
  always_ff @(posedge link_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dq_o <= '0;
      dq_oe_o <= 1'b0;
      strobe_oe_o <= 1'b0;
      lower_byte_strobe_o <= 1'b0;
      lower_byte_strobe_n_o <= 1'b1;
      upper_byte_strobe_o <= 1'b0;
      upper_byte_strobe_n_o <= 1'b1;
    end else begin
      dq_o <= rd_launch ? rd_word_c : '0;
      dq_oe_o <= rd_launch;
      strobe_oe_o <= rd_launch;
      lower_byte_strobe_o <= rd_launch;
      lower_byte_strobe_n_o <= !rd_launch;
      upper_byte_strobe_o <= rd_launch && org_x16;
      upper_byte_strobe_n_o <= !(rd_launch && org_x16);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // core domain: toggles synchronised, words taken from stable holding regs

  logic wrt_s1;
  logic wrt_s2;
  logic wrt_s3;
  logic rdt_s1;
  logic rdt_s2;
  logic rdt_s3;
  logic tstrobe_s1;
  logic fifo_in_ready;
  logic [WORD_W-1:0] fifo_out;

  wire wr_evt = wrt_s2 ^ wrt_s3;
  wire rd_evt = rdt_s2 ^ rdt_s3;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wrt_s1 <= 1'b0;
      wrt_s2 <= 1'b0;
      wrt_s3 <= 1'b0;
      rdt_s1 <= 1'b0;
      rdt_s2 <= 1'b0;
      rdt_s3 <= 1'b0;
      tstrobe_s1 <= 1'b0;
      termination_strobe_en_o <= 1'b0;
    end else begin
      wrt_s1 <= wr_tog_l;
      wrt_s2 <= wrt_s1;
      wrt_s3 <= wrt_s2;
      rdt_s1 <= rd_tog_l;
      rdt_s2 <= rdt_s1;
      rdt_s3 <= rdt_s2;
      tstrobe_s1 <= mr_tstrobe;
      termination_strobe_en_o <= tstrobe_s1;
    end
  end

  // a beat that finds the fifo full is lost and flagged
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_overflow_o <= 1'b0;
      wr_in_ready_o <= 1'b0;
    end else begin
      wr_in_ready_o <= fifo_in_ready;
      if (wr_evt && !fifo_in_ready) begin
        wr_overflow_o <= 1'b1;
      end
    end
  end

  dpi_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .in_valid_i(wr_evt),
    .in_ready_o(fifo_in_ready),
    .in_data_i(wr_word_l),
    .out_valid_o(wr_valid_o),
    .out_ready_i(wr_ready_i),
    .out_data_o(fifo_out)
  );

  assign {wr_bank_o, wr_addr_o, wr_byte_en_o, wr_data_o} = fifo_out;

  // read request pulse out, answer word held and toggled back to the link
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_req_o <= 1'b0;
      rd_bank_o <= '0;
      rd_addr_o <= '0;
      rd_tog_c <= 1'b0;
      rd_word_c <= '0;
    end else begin
      rd_req_o <= rd_evt;
      if (rd_evt) begin
        rd_bank_o <= rd_bank_l;
        rd_addr_o <= rd_addr_l;
      end
      if (rd_valid_i) begin
        rd_word_c <= rd_data_i;
        rd_tog_c <= !rd_tog_c;
      end
    end
  end

endmodule

`default_nettype wire

// file: verification/dpi_top_sva.sv
// concurrent checks on the ddr3 pin interface ports
`timescale 1ns/1ns
`default_nettype none

module dpi_top_chk (
  // clocks and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic link_clk_i,
  // link side
  input wire logic termination_enable_i,
  input wire logic dq_oe_o,
  input wire logic lower_byte_strobe_o,
  input wire logic lower_byte_strobe_n_o,
  input wire logic upper_byte_strobe_o,
  input wire logic [15:0] term_dq_o,
  input wire logic [1:0] term_strobe_o,
  input wire logic [1:0] term_mask_o,
  input wire logic term_strobe_n_ball_o,
  // core side
  input wire logic wr_valid_o,
  input wire logic [1:0] wr_byte_en_o,
  input wire logic [15:0] wr_data_o,
  input wire logic rd_req_o
);
  ////////////////////////////////////////////////////////////////////////////
  // read beat: lower strobe pair driven, then data output released the next link cycle
  sequence s_read_beat;
    lower_byte_strobe_o && !lower_byte_strobe_n_o ##1 !dq_oe_o;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  term_ena_a: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
    term_dq_o != 16'h0 |-> $past(termination_enable_i) || $past(termination_enable_i, 2))
    else $error("termination on without enable");
  x16_balls_a: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
    term_dq_o == 16'hffff |-> term_strobe_o == 2'h3 && term_mask_o == 2'h3)
    else $error("x16 ball set wrong");
  x8_balls_a: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
    term_strobe_n_ball_o |-> term_dq_o == 16'h00ff && term_strobe_o == 2'h1)
    else $error("complement strobe ball outside x8");
  x4_balls_a: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
    term_dq_o == 16'h000f |-> term_mask_o == 2'h1 && !term_strobe_n_ball_o)
    else $error("x4 ball set wrong");
  read_strobe_a: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
    $rose(dq_oe_o) |-> s_read_beat)
    else $error("lower strobe not with read beat");
  upper_strobe_a: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
    upper_byte_strobe_o |-> dq_oe_o)
    else $error("upper strobe outside read beat");
  upper_mask_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    wr_valid_o && !wr_byte_en_o[1] |-> wr_data_o[15:8] == 8'h0)
    else $error("masked upper byte kept");
  lower_mask_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    wr_valid_o && !wr_byte_en_o[0] |-> wr_data_o[7:0] == 8'h0)
    else $error("masked lower byte kept");
  reset_clear_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    $rose(rstn_i) |-> !wr_valid_o && !rd_req_o)
    else $error("outputs active after reset");
  read_pulse_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
    rd_req_o |=> !rd_req_o)
    else $error("read request longer than one cycle");
endmodule

bind dpi_top dpi_top_chk i_chk (.clock_i, .rstn_i, .link_clk_i, .termination_enable_i,
  .dq_oe_o, .lower_byte_strobe_o, .lower_byte_strobe_n_o, .upper_byte_strobe_o,
  .term_dq_o, .term_strobe_o, .term_mask_o, .term_strobe_n_ball_o, .wr_valid_o,
  .wr_byte_en_o, .wr_data_o, .rd_req_o);

`default_nettype wire

// file: verification/dpi_host_model.sv
// controller-side pin driver for the ddr3 interface
`timescale 1ns/1ns
`default_nettype none

module dpi_host_model (
  // link clock
  input wire logic link_clk_i,
  // pins toward the memory: cmd is {cs_n, ras_n, cas_n, we_n}
  output logic [3:0] cmd_o,
  output logic [2:0] bank_o,
  output logic [13:0] addr_o,
  output logic term_en_o,
  output logic [15:0] dq_o,
  output logic [1:0] mask_o
);
  initial begin
    cmd_o = 4'hf;
    bank_o = 3'h0;
    addr_o = 14'h0;
    term_en_o = 1'b0;
    dq_o = 16'h0;
    mask_o = 2'h0;
  end

  task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
    @(posedge link_clk_i);
    #1;
    cmd_o = c;
    bank_o = b;
    addr_o = a;
    @(posedge link_clk_i);
    #1;
    // deselected: command lines scrambled so stale codes never look valid
    cmd_o = {1'b1, ~c[2:0]};
    bank_o = ~b;
    addr_o = ~a;
  endtask

  task automatic write(input logic [2:0] b, input logic [13:0] a, input logic [15:0] d,
                       input logic [1:0] m);
    issue(4'h4, b, a);
    dq_o = d;
    mask_o = m;
    @(posedge link_clk_i);
    #1;
    dq_o = ~d;
    mask_o = ~m;
  endtask

  task automatic set_term(input logic v);
    @(posedge link_clk_i);
    #1;
    term_en_o = v;
  endtask
endmodule

`default_nettype wire

// file: verification/dpi_top_tb.sv
// self-checking bench for the ddr3 pin interface
`timescale 1ns/1ns
`default_nettype none

module dpi_top_tb;
  import dpi_pkg::*;
  logic clock_i = 1'b0, link_clk_i = 1'b0, rstn_i = 1'b0, wr_ready_i = 1'b0, rd_valid_i = 1'b0;
  logic [1:0] org_i = ORG_X16;
  logic [15:0] rd_data_i = 16'h0;
  wire logic cs_n_i, ras_n_i, cas_n_i, we_n_i, termination_enable_i;
  wire logic lower_write_mask_i, upper_write_mask_i;
  wire logic [2:0] bank_i;
  wire logic [13:0] addr_i;
  wire logic [15:0] dq_i;
  logic [15:0] dq_o, term_dq_o, wr_data_o;
  logic dq_oe_o, lower_byte_strobe_o, lower_byte_strobe_n_o, upper_byte_strobe_o;
  logic upper_byte_strobe_n_o, strobe_oe_o, term_strobe_n_ball_o, termination_strobe_en_o;
  logic wr_valid_o, wr_in_ready_o, wr_overflow_o, rd_req_o;
  logic [1:0] term_strobe_o, term_mask_o, wr_byte_en_o;
  logic [2:0] wr_bank_o, rd_bank_o;
  logic [13:0] wr_addr_o, rd_addr_o;
  int mismatches = 0, cmp_count = 0, seed = 1;
  logic [34:0] exp_q[$];

  dpi_top i_dut (.*);
  dpi_host_model i_host (.link_clk_i(link_clk_i), .cmd_o({cs_n_i, ras_n_i, cas_n_i, we_n_i}),
    .bank_o(bank_i), .addr_o(addr_i), .term_en_o(termination_enable_i), .dq_o(dq_i),
    .mask_o({upper_write_mask_i, lower_write_mask_i}));

  initial forever #5 clock_i = ~clock_i;
  initial begin
    #3;
    forever #40 link_clk_i = ~link_clk_i;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [34:0] got, input logic [34:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // sel 0: write word, 1: read request, 2: read beat
  task automatic wait_hi(input int sel);
    int n;
    n = 0;
    do begin
      @(posedge clock_i);
      #1;
      n++;
    end while ((sel == 0 ? wr_valid_o : sel == 1 ? rd_req_o : dq_oe_o) !== 1'b1 && n < 500);
    if ((sel == 0 ? wr_valid_o : sel == 1 ? rd_req_o : dq_oe_o) !== 1'b1) begin
      mismatches++;
      $display("ERROR %0t wait timed out", $time);
      tally_and_finish;
    end
  endtask

  // {dq, strobe, mask, complement strobe ball} while termination is on
  function automatic logic [20:0] term_exp(input logic [1:0] org, input logic ts);
    if (org == ORG_X16) begin
      return {16'hffff, 4'hf, 1'b0};
    end
    return {(org == ORG_X8) ? 16'h00ff : 16'h000f, 4'h5, org == ORG_X8 && ts};
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] d;
    logic [1:0] m;
    logic [13:0] a;
    logic [2:0] b;
    repeat (12) @(posedge clock_i);
    #1 rstn_i = 1'b1;
    chk({wr_valid_o, rd_req_o, lower_byte_strobe_n_o, term_dq_o}, {3'b001, 16'h0});
    for (int o = 0; o < 3; o++) begin
      for (int t = 0; t < 2; t++) begin
        @(posedge clock_i);
        #1 org_i = o[1:0];
        a = 14'h0;
        a[MR_TERM_EN_BIT] = 1'b1;
        a[MR_TSTROBE_BIT] = t[0];
        i_host.issue(4'h0, MR_TERM_BANK, a);
        i_host.set_term(1'b1);
        repeat (4) @(posedge link_clk_i);
        #2 chk({term_dq_o, term_strobe_o, term_mask_o, term_strobe_n_ball_o},
               term_exp(o[1:0], t[0]));
        chk(termination_strobe_en_o, t[0]);
        i_host.set_term(1'b0);
        repeat (4) @(posedge link_clk_i);
        #2 chk(term_dq_o, 16'h0);
      end
    end
    i_host.issue(4'h0, MR_TERM_BANK, 14'h0);
    i_host.set_term(1'b1);
    i_host.issue(4'h8, MR_TERM_BANK, 14'h4);
    repeat (4) @(posedge link_clk_i);
    #2 chk(term_dq_o, 16'h0);
    i_host.set_term(1'b0);
    // five beats into a four-word buffer with the core stalled
    for (int i = 0; i < 5; i++) begin
      {m, b, a, d} = 35'({$random(seed), $random(seed)});
      i_host.write(b, a, d, m);
      if (i < 4) exp_q.push_back({b, a, ~m, d & {{8{~m[1]}}, {8{~m[0]}}}});
    end
    repeat (10) @(posedge clock_i);
    #1 chk({wr_in_ready_o, wr_overflow_o}, 2'b01);
    while (exp_q.size() > 0) begin
      wait_hi(0);
      chk({wr_bank_o, wr_addr_o, wr_byte_en_o, wr_data_o}, exp_q.pop_front());
      wr_ready_i = 1'b1;
      @(posedge clock_i);
      #1 wr_ready_i = 1'b0;
      repeat (seed & 3) @(posedge clock_i);
    end
    repeat (4) @(posedge clock_i);
    #1 chk(wr_valid_o, 1'b0);
    for (int i = 0; i < 3; i++) begin
      // last read in x8: the upper strobe must stay parked
      @(posedge clock_i);
      #1 org_i = (i == 2) ? ORG_X8 : ORG_X16;
      {b, a, d} = 33'({$random(seed), $random(seed)});
      i_host.issue(4'h5, b, a);
      wait_hi(1);
      chk({rd_bank_o, rd_addr_o}, {b, a});
      rd_valid_i = 1'b1;
      rd_data_i = d;
      @(posedge clock_i);
      #1 rd_valid_i = 1'b0;
      rd_data_i = ~d;
      wait_hi(2);
      chk({dq_o, strobe_oe_o, lower_byte_strobe_o, lower_byte_strobe_n_o, upper_byte_strobe_o,
           upper_byte_strobe_n_o}, {d, 3'b110, org_i == ORG_X16, org_i != ORG_X16});
      repeat (16) @(posedge clock_i);
    end
    @(posedge clock_i);
    #1 rstn_i = 1'b0;
    #1 chk({wr_overflow_o, lower_byte_strobe_n_o, term_dq_o}, {2'b01, 16'h0});
    repeat (10) @(posedge clock_i);
    #1 rstn_i = 1'b1;
    repeat (2) @(posedge clock_i);
    #1 chk({wr_valid_o, wr_overflow_o, rd_req_o, dq_oe_o, term_dq_o}, {4'h0, 16'h0});
    repeat (4) @(posedge clock_i);
    tally_and_finish;
  end
endmodule

`default_nettype wire
